// >>> verilog/tmw_timer.sv
// Four-slot capture/compare/PWM timer with a 16-bit up-counter.
// Assumes a word-wide register port on clk_sys; pins are asynchronous.
//
// Overview of operation
// - Counter free-runs, counts once run bit set
// - Wrap FFFF to 0000 sets wrap flag
// - Clear-on-match A zeroes counter, sets flag A
// - Compare match drives pin low, high, toggle
// - Pin already at level stays unchanged
// - Selected pin edge captures counter into slot
// - Buffered capture moves slot A into C
// - PWM: A period, B/C/D duties, compare
// - PWM pin goes init at A, inverse at duty
// - PWM pins ignore per-slot compare codes
// - Equal period and duty leave pin unchanged
// - PWM B buffered: match B loads D into B
// - Match fires when counter advances past value
// - Cleared counter spans 0..N, N+1 ticks
// - Capture event sets the slot match flag
// - Flag clears by read-one then write-zero
// - Clear beats counter write, write beats count
// - Count on rising edge of selected source
// - Init level bits set pins until match
// - Control write beats coincident match pin change
// - Two-bit code: compare action or capture edge
// - Buffered compare copies slot C into A
// - Counter and slots accessed as whole words
// - Reset sets all four slots to FFFF
`include "tmw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tmw_timer #(
    parameter int PRESC_W = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire tmw_pkg::tmw_addr_t regAddr,
    input wire tmw_pkg::tmw_word_t regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output tmw_pkg::tmw_word_t regRdata,
    input wire logic extClkIn,
    input wire logic [3:0] timerPinIn,
    output logic [3:0] timerPinOut,
    output logic [3:0] timerPinOe,
    output logic irqReq
);
    import tmw_pkg::*;

    // ==========================================
    // Helpers
    function automatic logic edgeHit(input logic [1:0] sel, input logic prv,
                                     input logic cur);
        edgeHit = sel[1] ? (prv != cur) : (sel[0] ? (prv && !cur) : (!prv && cur));
    endfunction : edgeHit

    function automatic logic pinAct(input tmw_act_t act, input logic cur);
        unique case (act)
            TMW_ACT_NONE: pinAct = cur;
            TMW_ACT_LOW: pinAct = 1'b0;
            TMW_ACT_HIGH: pinAct = 1'b1;
            TMW_ACT_TOGGLE: pinAct = !cur;
        endcase
    endfunction : pinAct

    // ==========================================
    // State
    tmw_word_t count_reg, count_next;
    tmw_word_t slot_reg [4];
    tmw_word_t slot_next [4];
    tmw_word_t mode_reg, mode_next, ctrl_reg, ctrl_next, ien_reg, ien_next;
    tmw_word_t flag_reg, flag_next, func0_reg, func0_next, func1_reg, func1_next;
    tmw_word_t readSeen_reg, readSeen_next, rdata_reg, rdata_next;
    logic [3:0] pin_reg, pin_next, oe_reg, oe_next;
    logic irq_reg, irq_next, srcPrev_reg, srcPrev_next;
    logic [PRESC_W-1:0] presc_reg, presc_next;
    logic [3:0] pinSync1_reg, pinSync2_reg, pinPrev_reg;
    logic extSync1_reg, extSync2_reg;

    // ==========================================
    // Decode
    logic [3:0] pwmEn, isCap, capEv, matchEv;
    logic [2:0] fld [4];
    logic run, srcBit, tick, cntWr, ctrlWr, clrA, wrapEv;

    assign run = mode_reg[`TMW_MODE_RUN];
    assign pwmEn = {mode_reg[3:1], 1'b0};
    assign cntWr = regWr && (regAddr == `TMW_ADDR_COUNT);
    assign ctrlWr = regWr && (regAddr == `TMW_ADDR_CTRL);
    assign srcBit = ctrl_reg[`TMW_CTRL_EXT] ? extSync2_reg
                  : presc_reg[ctrl_reg[`TMW_CTRL_DIV_LO +: 2]];
    assign tick = run && srcBit && !srcPrev_reg;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gSlot
            if (g < 2)
            begin : gLo
                assign fld[g] = func0_reg[4*g +: 3];
            end
            else
            begin : gHi
                assign fld[g] = func1_reg[4*(g-2) +: 3];
            end
            assign isCap[g] = fld[g][`TMW_FUNC_CAP] && !pwmEn[g] && !(g == 0 && |pwmEn);
            assign capEv[g] = isCap[g] && edgeHit(fld[g][1:0], pinPrev_reg[g], pinSync2_reg[g]);
            assign matchEv[g] = !isCap[g] && tick && (count_reg == slot_reg[g]);
        end
    endgenerate

    assign clrA = matchEv[0] && ctrl_reg[`TMW_CTRL_CLEAR_ON_MATCH];
    assign wrapEv = tick && (count_reg == `TMW_COUNT_MAX) && !clrA && !cntWr;

    // ==========================================
    // Next state
    always_comb
    begin
        count_next = count_reg;
        slot_next = slot_reg;
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        ien_next = ien_reg;
        flag_next = flag_reg;
        func0_next = func0_reg;
        func1_next = func1_reg;
        readSeen_next = readSeen_reg;
        pin_next = pin_reg;
        rdata_next = '0;
        presc_next = presc_reg + 1'b1;
        srcPrev_next = srcBit;
        if (clrA)
            count_next = `TMW_COUNT_RST;
        else if (cntWr)
            count_next = regWdata;
        else if (tick)
            count_next = count_reg + 1'b1;
        if (regWr)
        begin
            unique case (regAddr)
                `TMW_ADDR_MODE: mode_next = regWdata & `TMW_MODE_MASK;
                `TMW_ADDR_CTRL: ctrl_next = regWdata & `TMW_CTRL_MASK;
                `TMW_ADDR_IEN: ien_next = regWdata & `TMW_FLAG_MASK;
                `TMW_ADDR_FUNC0: func0_next = regWdata & `TMW_FUNC_MASK;
                `TMW_ADDR_FUNC1: func1_next = regWdata & `TMW_FUNC_MASK;
                default:
                    if (regAddr[3:2] == `TMW_ADDR_SLOT)
                        slot_next[regAddr[1:0]] = regWdata;
            endcase
        end
        for (int i = 0; i < 4; i++)
        begin
            if (capEv[i])
                slot_next[i] = count_reg;
        end
        if (mode_reg[`TMW_MODE_BUFA] && capEv[0])
            slot_next[2] = slot_reg[0];
        if (mode_reg[`TMW_MODE_BUFA] && matchEv[0])
            slot_next[0] = slot_reg[2];
        if (mode_reg[`TMW_MODE_BUFB] && capEv[1])
            slot_next[3] = slot_reg[1];
        if (mode_reg[`TMW_MODE_BUFB] && matchEv[1])
            slot_next[1] = slot_reg[3];
        for (int i = 0; i < 4; i++)
        begin
            if (pwmEn[i])
            begin
                if (slot_reg[0] != slot_reg[i])
                begin
                    if (matchEv[0])
                        pin_next[i] = ctrl_reg[i];
                    if (matchEv[i])
                        pin_next[i] = !ctrl_reg[i];
                end
            end
            else if (matchEv[i])
                pin_next[i] = pinAct(tmw_act_t'(fld[i][1:0]), pin_reg[i]);
        end
        if (ctrlWr)
            pin_next = regWdata[3:0];
        if (regRd && regAddr == `TMW_ADDR_FLAG)
            readSeen_next = readSeen_reg | flag_reg;
        if (regWr && regAddr == `TMW_ADDR_FLAG)
        begin
            flag_next = flag_reg & ~(readSeen_reg & ~regWdata);
            readSeen_next = '0;
        end
        flag_next = flag_next | {8'h00, wrapEv, 3'b000, matchEv | capEv};
        oe_next = ~isCap;
        irq_next = |(flag_next & ien_next);
        if (regRd)
        begin
            unique case (regAddr)
                `TMW_ADDR_MODE: rdata_next = mode_reg;
                `TMW_ADDR_CTRL: rdata_next = ctrl_reg;
                `TMW_ADDR_IEN: rdata_next = ien_reg;
                `TMW_ADDR_FLAG: rdata_next = flag_reg;
                `TMW_ADDR_FUNC0: rdata_next = func0_reg | `TMW_FUNC_RSVD;
                `TMW_ADDR_FUNC1: rdata_next = func1_reg | `TMW_FUNC_RSVD;
                `TMW_ADDR_COUNT: rdata_next = count_reg;
                default:
                    if (regAddr[3:2] == `TMW_ADDR_SLOT)
                        rdata_next = slot_reg[regAddr[1:0]];
            endcase
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            count_reg <= `TMW_COUNT_RST;
            slot_reg <= '{default: `TMW_SLOT_RST};
            mode_reg <= '0;
            ctrl_reg <= '0;
            ien_reg <= '0;
            flag_reg <= '0;
            func0_reg <= '0;
            func1_reg <= '0;
            readSeen_reg <= '0;
            rdata_reg <= '0;
            pin_reg <= '0;
            oe_reg <= '0;
            irq_reg <= 1'b0;
            srcPrev_reg <= 1'b0;
            presc_reg <= '0;
            pinSync1_reg <= '0;
            pinSync2_reg <= '0;
            pinPrev_reg <= '0;
            extSync1_reg <= 1'b0;
            extSync2_reg <= 1'b0;
        end
        else if (ce)
        begin
            count_reg <= count_next;
            slot_reg <= slot_next;
            mode_reg <= mode_next;
            ctrl_reg <= ctrl_next;
            ien_reg <= ien_next;
            flag_reg <= flag_next;
            func0_reg <= func0_next;
            func1_reg <= func1_next;
            readSeen_reg <= readSeen_next;
            rdata_reg <= rdata_next;
            pin_reg <= pin_next;
            oe_reg <= oe_next;
            irq_reg <= irq_next;
            srcPrev_reg <= srcPrev_next;
            presc_reg <= presc_next;
            pinSync1_reg <= timerPinIn;
            pinSync2_reg <= pinSync1_reg;
            pinPrev_reg <= pinSync2_reg;
            extSync1_reg <= extClkIn;
            extSync2_reg <= extSync1_reg;
        end
    end

    assign regRdata = rdata_reg;
    assign timerPinOut = pin_reg;
    assign timerPinOe = oe_reg;
    assign irqReq = irq_reg;

    // ==========================================
    // Checks
    AST_STOPPED: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && !run && !cntWr |=> count_reg == $past(count_reg))
        else $error("Counter moved while stopped");
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && wrapEv |=> flag_reg[`TMW_WRAP_BIT] && count_reg == `TMW_COUNT_RST)
        else $error("Wrap did not set flag");
    AST_CLEAR_A: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && clrA |=> count_reg == `TMW_COUNT_RST && flag_reg[0])
        else $error("Match A did not clear counter");
    AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && capEv[1] && !regWr |=> slot_reg[1] == $past(count_reg) && flag_reg[1])
        else $error("Capture B lost");
    AST_BUF_CAP: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && capEv[0] && mode_reg[`TMW_MODE_BUFA] && !regWr
        |=> slot_reg[2] == $past(slot_reg[0]))
        else $error("Buffered capture did not move slot A");
    AST_MATCH_TICK: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(flag_reg[0]) |-> $past(capEv[0])
        || ($past(tick) && $past(count_reg) == $past(slot_reg[0])))
        else $error("Flag A set without counter advance");
    AST_PWM_EQUAL: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && pwmEn[1] && slot_reg[0] == slot_reg[1] && !ctrlWr
        |=> $stable(pin_reg[1]))
        else $error("PWM pin moved with equal slots");
    AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
        $fell(flag_reg[0]) |-> $past(regWr && regAddr == `TMW_ADDR_FLAG && readSeen_reg[0]))
        else $error("Flag cleared without read then write");
    AST_INIT_LEVEL: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && ctrlWr |=> pin_reg == $past(regWdata[3:0]))
        else $error("Control write did not set pins");
    AST_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst)
        irqReq == |(flag_reg & ien_reg))
        else $error("Interrupt does not follow flags");
    AST_WRITE_WINS: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && cntWr && !clrA |=> count_reg == $past(regWdata))
        else $error("Counter write lost to count");
    AST_DRIVE_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && matchEv[1] && !pwmEn[1] && tmw_act_t'(fld[1][1:0]) == TMW_ACT_LOW && !ctrlWr
        |=> !pin_reg[1])
        else $error("Match B did not drive pin low");
    AST_PWM_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && pwmEn[1] && matchEv[0] && !matchEv[1] && slot_reg[0] != slot_reg[1] && !ctrlWr
        |=> pin_reg[1] == $past(ctrl_reg[1]))
        else $error("PWM pin missed its period level");
    AST_PWM_OE: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && |pwmEn |=> oe_reg[0])
        else $error("Period slot not forced to compare");
endmodule : tmw_timer
`default_nettype wire

// >>> verilog/tmw_defines.svh
// Register offsets, field positions, reset values for the capture/compare timer.
// Assumes a 16-bit word register port with four address bits.
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH
// ==========================================
// Offsets
`define TMW_ADDR_MODE 4'h0
`define TMW_ADDR_CTRL 4'h1
`define TMW_ADDR_IEN 4'h2
`define TMW_ADDR_FLAG 4'h3
`define TMW_ADDR_FUNC0 4'h4
`define TMW_ADDR_FUNC1 4'h5
`define TMW_ADDR_COUNT 4'h6
`define TMW_ADDR_SLOT 2'h2
// ==========================================
// Fields
`define TMW_MODE_RUN 7
`define TMW_MODE_BUFA 4
`define TMW_MODE_BUFB 5
`define TMW_MODE_MASK 16'h00BE
`define TMW_CTRL_CLEAR_ON_MATCH 7
`define TMW_CTRL_EXT 6
`define TMW_CTRL_DIV_LO 4
`define TMW_CTRL_MASK 16'h00FF
`define TMW_WRAP_BIT 7
`define TMW_FLAG_MASK 16'h008F
`define TMW_FUNC_CAP 2
`define TMW_FUNC_MASK 16'h0077
`define TMW_FUNC_RSVD 16'h0088
// ==========================================
// Reset values
`define TMW_SLOT_RST 16'hFFFF
`define TMW_COUNT_RST 16'h0000
`define TMW_COUNT_MAX 16'hFFFF
`endif

// >>> verilog/tmw_pkg.sv
// Types shared by the capture/compare timer.
// Assumes tmw_defines.svh holds the numbers.
// ==========================================
// Types
package tmw_pkg;
    typedef logic [15:0] tmw_word_t;
    typedef logic [3:0] tmw_addr_t;
    typedef enum logic [1:0] {
        TMW_ACT_NONE = 2'b00,
        TMW_ACT_LOW = 2'b01,
        TMW_ACT_HIGH = 2'b10,
        TMW_ACT_TOGGLE = 2'b11
    } tmw_act_t;
endpackage : tmw_pkg

// >>> tb/tmw_pin_model.sv
// Far side of the timer pins: pads and capture sources.
// Assumes one clock; the bench sets capture levels.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Pad model
module tmw_pin_model (
    input wire logic clk_sys,
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe,
    input wire logic [3:0] capLevel,
    output logic [3:0] pinIn
);
    initial pinIn = 4'h0;
    // levels held long
    // Driven pads read back their own level; undriven capture pins read capLevel, so a capture pin never floats
    always @(posedge clk_sys)
    begin
        pinIn <= (pinOe & pinOut) | (~pinOe & capLevel);
    end
endmodule : tmw_pin_model
`default_nettype wire

// >>> tb/tmw_timer_tb_top.sv
// Self-checking bench for the capture/compare timer.
// Assumes prescale /2 or /4 (tick every 2 or 4 clocks) and a stopped counter for captures.
`include "tmw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench
module tmw_timer_tb_top;
    import tmw_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    tmw_addr_t regAddr = 4'h0;
    tmw_word_t regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    tmw_word_t regRdata;
    logic [3:0] pinIn;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
    logic [3:0] capLevel = 4'h0;
    logic extClk = 1'b0;
    logic irqReq;
    logic rdPend = 1'b0;
    tmw_word_t expQ[$];
    tmw_word_t capV;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int hi;
    int lo;
    int n;

    always #2.5 clk_sys = ~clk_sys;

    tmw_timer #(.PRESC_W(4)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .extClkIn(extClk), .timerPinIn(pinIn),
        .timerPinOut(pinOut), .timerPinOe(pinOe), .irqReq(irqReq));
    tmw_pin_model i_pins (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
        .capLevel(capLevel), .pinIn(pinIn));

    task automatic results();
        $display("TB: checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic cmpWord(input string what, input tmw_word_t exp, input tmw_word_t got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpWord

    task automatic wr(input tmw_addr_t a, input tmw_word_t d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input tmw_addr_t a, input tmw_word_t e);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk_sys);
        regRd <= 1'b0;
    endtask : rd

    task automatic waitLvl(input int idx, input logic lvl, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk_sys);
            cnt++;
        end
        while (pinOut[idx] !== lvl && cnt < 400);
    endtask : waitLvl

    task automatic pinWidth(input int idx, input int expHi, input int expPer);
        waitLvl(idx, 1'b0, n);
        waitLvl(idx, 1'b1, n);
        waitLvl(idx, 1'b0, hi);
        waitLvl(idx, 1'b1, lo);
        cmpWord("pin high width", 16'(expHi), 16'(hi));
        cmpWord("pin period", 16'(expPer), 16'(hi + lo));
    endtask : pinWidth

    // ====================
    // Read checker and timeout
    // Read data stand only in the cycle after the strobe, so look exactly there
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (rdPend)
        begin
            cmpWord("read data", expQ.pop_front(), regRdata);
        end
        rdPend <= regRd;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end

    // ====================
    // Scenarios
    initial
    begin
        void'($urandom(32'hc80c));
        capV = 16'($urandom());
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rd(`TMW_ADDR_COUNT, 16'h0000);
        wr(`TMW_ADDR_COUNT, 16'h0005);
        rd(`TMW_ADDR_COUNT, 16'h0005);
        for (int i = 0; i < 4; i++)
        begin
            rd(4'h8 + 4'(i), 16'hFFFF);
        end
        rd(4'h7, 16'h0000);
        rd(`TMW_ADDR_FUNC1, 16'h0088);
        wr(`TMW_ADDR_FUNC1, 16'h0040);
        wr(`TMW_ADDR_COUNT, capV);
        cmpWord("pin enable", 16'h0007, 16'(pinOe));
        capLevel <= 4'h8;
        repeat (10) @(posedge clk_sys);
        rd(4'hB, capV);
        wr(`TMW_ADDR_COUNT, capV + 16'h0001);
        capLevel <= 4'h0;
        repeat (10) @(posedge clk_sys);
        rd(4'hB, capV);
        wr(`TMW_ADDR_FUNC0, 16'h0066);
        wr(`TMW_ADDR_MODE, 16'h0010);
        wr(`TMW_ADDR_COUNT, 16'h1234);
        capLevel <= 4'h3;
        repeat (10) @(posedge clk_sys);
        wr(`TMW_ADDR_COUNT, 16'h5678);
        capLevel <= 4'h0;
        repeat (10) @(posedge clk_sys);
        rd(4'h8, 16'h5678);
        rd(4'hA, 16'h1234);
        rd(4'h9, 16'h5678);
        rd(`TMW_ADDR_FLAG, 16'h000B);
        wr(`TMW_ADDR_FLAG, 16'h0000);
        wr(`TMW_ADDR_FUNC0, 16'h0000);
        wr(`TMW_ADDR_FUNC1, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h8 + 4'(i), 16'h8000);
        end
        wr(`TMW_ADDR_IEN, 16'h0080);
        wr(`TMW_ADDR_COUNT, 16'hFFF0);
        wr(`TMW_ADDR_MODE, 16'h0080);
        repeat (60) @(posedge clk_sys);
        wr(`TMW_ADDR_MODE, 16'h0000);
        cmpWord("irq raised", 16'h0001, 16'(irqReq));
        wr(`TMW_ADDR_FLAG, 16'h0000);
        rd(`TMW_ADDR_FLAG, 16'h0080);
        wr(`TMW_ADDR_FLAG, 16'h0000);
        rd(`TMW_ADDR_FLAG, 16'h0000);
        repeat (2) @(posedge clk_sys);
        cmpWord("irq dropped", 16'h0000, 16'(irqReq));
        wr(`TMW_ADDR_COUNT, 16'h0000);
        wr(4'h8, 16'h0003);
        wr(4'h9, 16'h0001);
        wr(`TMW_ADDR_FUNC0, 16'h0013);
        wr(`TMW_ADDR_CTRL, 16'h0092);
        repeat (2) @(posedge clk_sys);
        cmpWord("pin B init", 16'h0001, 16'(pinOut[1]));
        wr(`TMW_ADDR_MODE, 16'h0080);
        pinWidth(0, 16, 32);
        cmpWord("pin B low", 16'h0000, 16'(pinOut[1]));
        wr(`TMW_ADDR_MODE, 16'h0000);
        wr(`TMW_ADDR_COUNT, 16'h0000);
        wr(4'h8, 16'h0007);
        wr(4'h9, 16'h0002);
        wr(`TMW_ADDR_FUNC0, 16'h0010);
        wr(`TMW_ADDR_CTRL, 16'h0082);
        wr(`TMW_ADDR_MODE, 16'h0082);
        pinWidth(1, 6, 16);
        wr(4'hB, 16'h0004);
        wr(`TMW_ADDR_MODE, 16'h00A2);
        repeat (40) @(posedge clk_sys);
        pinWidth(1, 10, 16);
        wr(`TMW_ADDR_MODE, 16'h0082);
        wr(4'h9, 16'h0007);
        repeat (40) @(posedge clk_sys);
        waitLvl(1, ~pinOut[1], n);
        cmpWord("pin B steady", 16'h0190, 16'(n));
        wr(`TMW_ADDR_MODE, 16'h0000);
        wr(`TMW_ADDR_IEN, 16'h0000);
        wr(`TMW_ADDR_COUNT, 16'h0000);
        wr(`TMW_ADDR_CTRL, 16'h0040);
        wr(`TMW_ADDR_MODE, 16'h0080);
        // External pulses held three clocks each side
        repeat (5)
        begin
            extClk <= 1'b1;
            repeat (3) @(posedge clk_sys);
            extClk <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        wr(`TMW_ADDR_MODE, 16'h0000);
        rd(`TMW_ADDR_COUNT, 16'h0005);
        repeat (3) @(posedge clk_sys);
        results();
    end
endmodule : tmw_timer_tb_top
`default_nettype wire
